//--- core/uep_ep0_ctrl.sv
// Purpose: Endpoint 0 handshaking, session/role status and high-speed test modes
// Assumes: Link events are synchronous one-cycle pulses; register read data one cycle late
// Notes: All outputs come from the state flip-flops
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module uep_ep0_ctrl (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire uep_pkg::uep_link_in_t link_in,
	output uep_pkg::uep_link_out_t link_out
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] rdata;
		logic [7:0] test;
		logic sess;
		logic hreq;
		logic bdev;
		logic fs_peer;
		logic ls_peer;
		logic [1:0] vbus;
		logic stall_req;
		logic early;
		logic last;
		logic ssent;
		logic txl;
		logic rxp;
		logic noping;
		logic nakto;
		logic status;
		logic inreq;
		logic err;
		logic setup;
		logic srx;
		logic [7:0] cnt;
		logic [4:0] nakl;
		logic [4:0] nak_frames;
		logic nak_run;
		logic [1:0] tries;
		uep_pkg::uep_link_out_t lo;
	} uep_state_t;

	uep_state_t st_reg;
	uep_state_t st_next;
	logic wr_test;
	logic wr_role;
	logic wr_csr;
	logic host_now;
	logic [15:0] wd;

	// Write decode
	assign wr_test = reg_wr && (reg_addr == uep_pkg::OFS_TEST);
	assign wr_role = reg_wr && (reg_addr == uep_pkg::OFS_ROLE);
	assign wr_csr = reg_wr && (reg_addr == uep_pkg::OFS_EP0);
	assign wd = reg_wdata;
	assign host_now = st_reg.lo.host_mode;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		// Pulses last one cycle
		st_next.lo.srp_start = 1'b0;
		st_next.lo.hnp_start = 1'b0;
		st_next.lo.soft_disc = 1'b0;
		st_next.lo.fifo_flush = 1'b0;
		st_next.lo.loop_move = 1'b0;
		st_next.lo.ep0_event = 1'b0;

		// Test mode register: CPU fields
		if (wr_test) begin
			st_next.test[uep_pkg::TB_HOST] = wd[uep_pkg::TB_HOST];
			st_next.test[uep_pkg::TB_FS] = wd[uep_pkg::TB_FS];
			st_next.test[uep_pkg::TB_HS] = wd[uep_pkg::TB_HS];
			st_next.test[uep_pkg::TB_PKT] = wd[uep_pkg::TB_PKT];
			st_next.test[uep_pkg::TB_K] = wd[uep_pkg::TB_K];
			st_next.test[uep_pkg::TB_J] = wd[uep_pkg::TB_J];
			st_next.test[uep_pkg::TB_NAK] = wd[uep_pkg::TB_NAK];
			if (wd[uep_pkg::TB_LOOP] && !st_reg.test[uep_pkg::TB_LOOP]) begin
				st_next.test[uep_pkg::TB_LOOP] = 1'b1;
				st_next.lo.loop_move = 1'b1;
			end
		end
		// Loopback bit drops once the copy is done
		if (st_reg.test[uep_pkg::TB_LOOP] && link_in.loop_done) begin
			st_next.test[uep_pkg::TB_LOOP] = 1'b0;
		end

		// Speed on bus reset, from force bits or the chirp outcome
		if (link_in.usb_reset && !host_now) begin
			if (st_reg.test[uep_pkg::TB_HS] || link_in.hs_chirp_ok) begin
				st_next.lo.speed = uep_pkg::SPD_HIGH;
			end else begin
				st_next.lo.speed = uep_pkg::SPD_FULL;
			end
			if (st_reg.test[uep_pkg::TB_FS]) begin
				st_next.lo.speed = uep_pkg::SPD_FULL;
			end
		end

		// Test mode outputs: one at a time, high speed only
		st_next.lo.test_packet = 1'b0;
		st_next.lo.drive_k = 1'b0;
		st_next.lo.drive_j = 1'b0;
		st_next.lo.nak_all_in = 1'b0;
		if (st_reg.lo.speed == uep_pkg::SPD_HIGH) begin
			if (st_reg.test[uep_pkg::TB_PKT]) begin
				st_next.lo.test_packet = 1'b1;
			end else if (st_reg.test[uep_pkg::TB_K]) begin
				st_next.lo.drive_k = 1'b1;
			end else if (st_reg.test[uep_pkg::TB_J]) begin
				st_next.lo.drive_j = 1'b1;
			end else if (st_reg.test[uep_pkg::TB_NAK]) begin
				st_next.lo.nak_all_in = 1'b1;
			end
		end

		// Role, peer speed and VBUS level
		st_next.bdev = link_in.id_b;
		if (link_in.above_vbus_valid) begin
			st_next.vbus = 2'b11;
		end else if (link_in.above_a_valid) begin
			st_next.vbus = 2'b10;
		end else if (link_in.above_sess_end) begin
			st_next.vbus = 2'b01;
		end else begin
			st_next.vbus = 2'b00;
		end
		st_next.fs_peer = host_now && link_in.peer_connect && !link_in.peer_low;
		st_next.ls_peer = host_now && link_in.peer_connect && link_in.peer_low;

		// Session bit
		if (wr_role) begin
			st_next.hreq = wd[uep_pkg::RB_HREQ];
			if (!st_reg.bdev) begin
				st_next.sess = wd[uep_pkg::RB_SESS];
			end else if (wd[uep_pkg::RB_SESS] && !st_reg.sess) begin
				st_next.lo.srp_start = 1'b1;
			end else if (!wd[uep_pkg::RB_SESS] && link_in.suspended) begin
				st_next.sess = 1'b0;
				st_next.lo.soft_disc = 1'b1;
			end
		end
		if (st_reg.bdev && link_in.sess_end) begin
			st_next.sess = 1'b0;
		end
		if (st_reg.bdev && link_in.sess_start) begin
			st_next.sess = 1'b1;
		end

		// Host negotiation request
		if (st_reg.hreq && link_in.suspend_enter) begin
			st_next.lo.hnp_start = 1'b1;
		end
		if (st_reg.hreq && link_in.hnp_done) begin
			st_next.hreq = 1'b0;
		end

		// Host mode and forced-host speed
		st_next.lo.host_mode = st_reg.sess && (st_reg.test[uep_pkg::TB_HOST] ||
			(!st_reg.bdev && link_in.peer_connect));
		if (st_reg.sess && st_reg.test[uep_pkg::TB_HOST]) begin
			if (st_reg.test[uep_pkg::TB_HS]) begin
				st_next.lo.speed = uep_pkg::SPD_HIGH;
			end else if (st_reg.test[uep_pkg::TB_FS]) begin
				st_next.lo.speed = uep_pkg::SPD_FULL;
			end else begin
				st_next.lo.speed = uep_pkg::SPD_LOW;
			end
		end

		// Endpoint 0 software writes
		if (wr_csr) begin
			if (wd[uep_pkg::CB_TXL]) begin
				st_next.txl = 1'b1;
			end
			if (!host_now) begin
				if (wd[uep_pkg::CB_ACKEE]) begin
					st_next.early = 1'b0;
				end
				if (wd[uep_pkg::CB_ACKRX]) begin
					st_next.rxp = 1'b0;
				end
				if (wd[uep_pkg::CB_STALLREQ]) begin
					st_next.stall_req = 1'b1;
				end
				if (wd[uep_pkg::CB_LAST]) begin
					st_next.last = 1'b1;
				end
				if (!wd[uep_pkg::CB_SSENT]) begin
					st_next.ssent = 1'b0;
				end
			end else begin
				st_next.noping = wd[uep_pkg::CB_NOPING];
				st_next.status = wd[uep_pkg::CB_STATUS];
				st_next.inreq = wd[uep_pkg::CB_INREQ] | st_reg.inreq;
				st_next.setup = wd[uep_pkg::CB_SETUP];
				if (!wd[uep_pkg::CB_NAKTO]) begin
					st_next.nakto = 1'b0;
				end
				if (!wd[uep_pkg::CB_ERR]) begin
					st_next.err = 1'b0;
				end
				if (!wd[uep_pkg::CB_SRX]) begin
					st_next.srx = 1'b0;
				end
				if (!wd[uep_pkg::CB_RXP]) begin
					st_next.rxp = 1'b0;
				end
			end
			if (wd[uep_pkg::CB_FLUSH]) begin
				st_next.txl = 1'b0;
				st_next.rxp = 1'b0;
				st_next.lo.fifo_flush = 1'b1;
			end
		end

		// Link events; hardware sets win over software clears
		if (link_in.tx_sent && st_reg.txl) begin
			st_next.txl = 1'b0;
			st_next.setup = 1'b0;
			st_next.status = 1'b0;
			st_next.lo.ep0_event = 1'b1;
		end
		if (link_in.rx_got) begin
			st_next.rxp = 1'b1;
			st_next.inreq = 1'b0;
			st_next.status = 1'b0;
			st_next.lo.ep0_event = 1'b1;
		end
		if (link_in.stall_sent && st_reg.stall_req) begin
			st_next.stall_req = 1'b0;
			st_next.ssent = 1'b1;
			st_next.lo.ep0_event = 1'b1;
		end
		if (link_in.ctrl_done) begin
			st_next.last = 1'b0;
			if (!st_reg.last && !host_now) begin
				st_next.early = 1'b1;
				st_next.lo.ep0_event = 1'b1;
				st_next.lo.fifo_flush = 1'b1;
			end
		end
		if (host_now && link_in.stall_got) begin
			st_next.srx = 1'b1;
			st_next.lo.ep0_event = 1'b1;
		end

		// Attempts without any answer
		if (link_in.ack_got || link_in.nak_got || link_in.stall_got) begin
			st_next.tries = 2'b00;
		end else if (host_now && link_in.no_answer) begin
			st_next.tries = st_reg.tries + 2'b01;
			if (st_reg.tries + 2'b01 == uep_pkg::RETRY_LIMIT) begin
				st_next.err = 1'b1;
				st_next.tries = 2'b00;
				st_next.lo.ep0_event = 1'b1;
			end
		end

		// NAK limit in frames
		if (!host_now || link_in.ack_got || link_in.stall_got) begin
			st_next.nak_run = 1'b0;
			st_next.nak_frames = 5'h00;
		end else if (link_in.nak_got) begin
			st_next.nak_run = 1'b1;
		end
		if (host_now && st_reg.nak_run && link_in.frame_tick) begin
			if (st_reg.nak_frames >= st_reg.nakl) begin
				st_next.nakto = 1'b1;
				st_next.nak_run = 1'b0;
				st_next.nak_frames = 5'h00;
				st_next.lo.ep0_event = 1'b1;
			end else begin
				st_next.nak_frames = st_reg.nak_frames + 5'h01;
			end
		end
		if (reg_wr && (reg_addr == uep_pkg::OFS_NAKL)) begin
			st_next.nakl = wd[4:0];
		end

		// Received byte count
		st_next.cnt = link_in.rx_bytes;

		// Link commands
		st_next.lo.tx_armed = st_next.txl;
		st_next.lo.send_stall = st_next.stall_req;
		st_next.lo.setup_sel = st_next.setup;
		st_next.lo.force_data1 = st_next.status;
		st_next.lo.in_req = st_next.inreq && host_now;
		st_next.lo.no_ping = st_next.noping && host_now;
		st_next.lo.ep0_halted = st_next.nakto && host_now;

		// Read data, valid the cycle after the strobe
		st_next.rdata = uep_pkg::ZERO16;
		if (reg_rd) begin
			case (reg_addr)
				uep_pkg::OFS_TEST: begin
					st_next.rdata[7:0] = st_reg.test;
				end
				uep_pkg::OFS_ROLE: begin
					st_next.rdata[uep_pkg::RB_BDEV] = st_reg.bdev;
					st_next.rdata[uep_pkg::RB_FSP] = st_reg.fs_peer;
					st_next.rdata[uep_pkg::RB_LSP] = st_reg.ls_peer;
					st_next.rdata[uep_pkg::RB_VBH] = st_reg.vbus[1];
					st_next.rdata[uep_pkg::RB_VBL] = st_reg.vbus[0];
					st_next.rdata[uep_pkg::RB_HOST] = st_reg.lo.host_mode;
					st_next.rdata[uep_pkg::RB_HREQ] = st_reg.hreq;
					st_next.rdata[uep_pkg::RB_SESS] = st_reg.sess;
				end
				uep_pkg::OFS_EP0: begin
					st_next.rdata[uep_pkg::CB_TXL] = st_reg.txl;
					st_next.rdata[uep_pkg::CB_RXP] = st_reg.rxp;
					if (host_now) begin
						st_next.rdata[uep_pkg::CB_NOPING] = st_reg.noping;
						st_next.rdata[uep_pkg::CB_NAKTO] = st_reg.nakto;
						st_next.rdata[uep_pkg::CB_STATUS] = st_reg.status;
						st_next.rdata[uep_pkg::CB_INREQ] = st_reg.inreq;
						st_next.rdata[uep_pkg::CB_ERR] = st_reg.err;
						st_next.rdata[uep_pkg::CB_SETUP] = st_reg.setup;
						st_next.rdata[uep_pkg::CB_SRX] = st_reg.srx;
					end else begin
						st_next.rdata[uep_pkg::CB_STALLREQ] = st_reg.stall_req;
						st_next.rdata[uep_pkg::CB_EARLY] = st_reg.early;
						st_next.rdata[uep_pkg::CB_LAST] = st_reg.last;
						st_next.rdata[uep_pkg::CB_SSENT] = st_reg.ssent;
					end
				end
				uep_pkg::OFS_CNT0: begin
					st_next.rdata[7:0] = st_reg.cnt;
				end
				uep_pkg::OFS_CFG: begin
					st_next.rdata[7:0] = uep_pkg::CFG_FLAGS;
				end
				uep_pkg::OFS_NAKL: begin
					st_next.rdata[4:0] = st_reg.nakl;
				end
				default: begin
					st_next.rdata = uep_pkg::ZERO16;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.lo.speed <= uep_pkg::SPD_FULL;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state flip-flops
	assign reg_rdata = st_reg.rdata;
	assign link_out = st_reg.lo;
endmodule
`default_nettype wire

//--- core/uep_pkg.sv
// Purpose: Shared constants and carriers for the endpoint 0, session and test block
// Assumes: 200 MHz clock, register port with 16-bit data
// Notes: All control state resets to zero except the link speed, which resets to SPD_FULL
package uep_pkg;
	// Register offsets on the plain register port
	localparam logic [3:0] OFS_TEST = 4'h0;
	localparam logic [3:0] OFS_ROLE = 4'h1;
	localparam logic [3:0] OFS_EP0 = 4'h2;
	localparam logic [3:0] OFS_CNT0 = 4'h3;
	localparam logic [3:0] OFS_CFG = 4'h4;
	localparam logic [3:0] OFS_NAKL = 4'h5;
	// Test mode control bits
	localparam int TB_HOST = 7;
	localparam int TB_LOOP = 6;
	localparam int TB_FS = 5;
	localparam int TB_HS = 4;
	localparam int TB_PKT = 3;
	localparam int TB_K = 2;
	localparam int TB_J = 1;
	localparam int TB_NAK = 0;
	// Device role control and status bits
	localparam int RB_BDEV = 7;
	localparam int RB_FSP = 6;
	localparam int RB_LSP = 5;
	localparam int RB_VBH = 4;
	localparam int RB_VBL = 3;
	localparam int RB_HOST = 2;
	localparam int RB_HREQ = 1;
	localparam int RB_SESS = 0;
	// Endpoint 0 control/status bits
	localparam int CB_NOPING = 11;
	localparam int CB_FLUSH = 8;
	localparam int CB_ACKEE = 7;
	localparam int CB_NAKTO = 7;
	localparam int CB_ACKRX = 6;
	localparam int CB_STATUS = 6;
	localparam int CB_STALLREQ = 5;
	localparam int CB_INREQ = 5;
	localparam int CB_EARLY = 4;
	localparam int CB_ERR = 4;
	localparam int CB_LAST = 3;
	localparam int CB_SETUP = 3;
	localparam int CB_SSENT = 2;
	localparam int CB_SRX = 2;
	localparam int CB_TXL = 1;
	localparam int CB_RXP = 0;
	// Fixed build options: amalgamation, splitting, byte order, hb rx, hb tx,
	// dynamic fifo, soft connect, phy data width (0 = 8 bit)
	localparam logic [7:0] CFG_FLAGS = 8'h03;
	// Retries without an answer before the error flag
	localparam logic [1:0] RETRY_LIMIT = 2'h3;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// Link speed, one-hot
	typedef enum logic [2:0] {
		SPD_LOW = 3'b001,
		SPD_FULL = 3'b010,
		SPD_HIGH = 3'b100
	} uep_speed_t;
	// Events and levels from the link side, all synchronous
	typedef struct packed {
		logic usb_reset;      // Bus reset seen (peripheral)
		logic hs_chirp_ok;    // High-speed handshake succeeded during reset
		logic suspend_enter;  // Suspend entered
		logic suspended;      // Suspend level
		logic id_b;           // Cable id says B device
		logic peer_connect;   // Peer attached (host side)
		logic peer_low;       // Attached peer is low speed
		logic above_sess_end;
		logic above_a_valid;
		logic above_vbus_valid;
		logic sess_start;     // B device session began
		logic sess_end;       // B device session ended
		logic hnp_done;       // Host negotiation finished
		logic tx_sent;        // Endpoint 0 packet went out
		logic rx_got;         // Endpoint 0 packet arrived
		logic [7:0] rx_bytes; // Bytes now in the endpoint 0 fifo
		logic ctrl_done;      // Control transfer ended
		logic stall_sent;     // STALL handshake went out
		logic stall_got;      // STALL handshake received (host)
		logic nak_got;        // NAK received (host)
		logic ack_got;        // Any other handshake or data answer (host)
		logic no_answer;      // One attempt timed out (host)
		logic frame_tick;     // Frame or microframe start
		logic loop_done;      // Fifo loopback copy finished
	} uep_link_in_t;
	// Commands and status toward the link side
	typedef struct packed {
		uep_speed_t speed;
		logic host_mode;
		logic test_packet;
		logic drive_k;
		logic drive_j;
		logic nak_all_in;
		logic srp_start;      // Pulse
		logic hnp_start;      // Pulse
		logic soft_disc;      // Pulse
		logic fifo_flush;     // Pulse
		logic loop_move;      // Pulse
		logic ep0_event;      // Pulse toward the interrupt logic
		logic tx_armed;
		logic send_stall;
		logic setup_sel;
		logic force_data1;
		logic in_req;
		logic no_ping;
		logic ep0_halted;
	} uep_link_out_t;
endpackage

//--- tb/uep_ep0_ctrl_sva.sv
// Purpose: Port assertions for the endpoint 0, session and test block
// Assumes: One clock, nrst asynchronous and active low
// Notes: Sees only the ports of uep_ep0_ctrl; attached by bind
`timescale 1ns/1ps
`default_nettype none
module uep_ep0_ctrl_chk (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire uep_pkg::uep_link_in_t link_in,
	input wire uep_pkg::uep_link_out_t link_out
);
	// ----------------
	// Port relations
	// ----------------
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// A pulse that lasts exactly one cycle
	sequence one_shot(s);
		s ##1 !s;
	endsequence
	cfg_read_a: assert property (
		reg_rd && reg_addr == uep_pkg::OFS_CFG |=> reg_rdata == {8'h00, uep_pkg::CFG_FLAGS})
		else $error("build flag read wrong");
	count_read_a: assert property (
		reg_rd && reg_addr == uep_pkg::OFS_CNT0 && $stable(link_in.rx_bytes)
		|=> reg_rdata == {8'h00, $past(link_in.rx_bytes)}) else $error("byte count read wrong");
	loop_pulse_a: assert property (
		reg_wr && reg_addr == uep_pkg::OFS_TEST && reg_wdata[uep_pkg::TB_LOOP]
		|=> one_shot(link_out.loop_move)) else $error("loopback move not pulsed");
	flush_pulse_a: assert property (
		reg_wr && reg_addr == uep_pkg::OFS_EP0 && reg_wdata[uep_pkg::CB_FLUSH]
		|=> one_shot(link_out.fifo_flush)) else $error("flush not pulsed");
	test_single_a: assert property (
		$onehot0({link_out.test_packet, link_out.drive_k, link_out.drive_j, link_out.nak_all_in}))
		else $error("more than one test drive");
	tx_done_a: assert property (
		link_out.tx_armed && link_in.tx_sent && !reg_wr |=> !link_out.tx_armed && link_out.ep0_event)
		else $error("tx ready not cleared on send");
	stall_done_a: assert property (
		link_out.send_stall && link_in.stall_sent && !reg_wr |=> !link_out.send_stall)
		else $error("stall request not self-cleared");
	in_req_clr_a: assert property (
		link_out.in_req && link_in.rx_got && !reg_wr |=> !link_out.in_req)
		else $error("in request not cleared on receive");
endmodule
bind uep_ep0_ctrl uep_ep0_ctrl_chk u_uep_ep0_ctrl_chk (
	.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.link_in(link_in), .link_out(link_out)
);
`default_nettype wire

//--- tb/uep_link_model.sv
// Purpose: Link-side partner that answers endpoint 0 commands
// Assumes: Same clock as the block; bench events pass straight through
// Notes: dly sets the answer delay, 0 is prompt
`timescale 1ns/1ps
`default_nettype none
module uep_link_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [3:0] dly,
	input wire uep_pkg::uep_link_in_t ev,
	input wire uep_pkg::uep_link_out_t lo,
	output uep_pkg::uep_link_in_t li
);
	// ----------------
	// Handshake answers
	// ----------------
	logic [1:0] arm;
	logic [1:0] hit;
	logic [1:0][4:0] cnt;
	logic lp;
	assign arm = {lo.send_stall, lo.tx_armed};
	// Wait dly cycles after a request is armed, then answer once
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt <= '0;
			hit <= '0;
			lp <= 1'b0;
		end else begin
			lp <= lo.loop_move;
			for (int i = 0; i < 2; i++) begin
				hit[i] <= arm[i] && (cnt[i] == {1'b0, dly});
				if (!arm[i]) begin
					cnt[i] <= '0;
				end else if (cnt[i] <= {1'b0, dly}) begin
					cnt[i] <= cnt[i] + 5'h01;
				end
			end
		end
	end
	// Merge own answers into the bench events
	always_comb begin
		li = ev;
		li.tx_sent = ev.tx_sent | hit[0];
		li.stall_sent = ev.stall_sent | hit[1];
		li.loop_done = ev.loop_done | lp;
	end
endmodule
`default_nettype wire

//--- tb/uep_ep0_ctrl_tb_top.sv
// Purpose: Self-checking bench for the endpoint 0, session and test block
// Assumes: 200 MHz clock, link model on the far side
// Notes: Register tasks use one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module uep_ep0_ctrl_tb_top;
	// ----------------
	// Stimulus and checks
	// ----------------
	logic clock = 1'b0;
	logic nrst, reg_wr, reg_rd;
	logic [3:0] reg_addr, dly;
	logic [15:0] reg_wdata, reg_rdata, v;
	uep_pkg::uep_link_in_t ev, link_in;
	uep_pkg::uep_link_out_t link_out;
	int n_errors = 0, total_checks = 0, n_fl = 0, n_hnp = 0, n_srp = 0, n_disc = 0;
	logic [15:0] tm_w [5] = '{16'h0014, 16'h0012, 16'h0011, 16'h0018, 16'h001f};
	logic [3:0] tm_e [5] = '{4'h4, 4'h2, 4'h1, 4'h8, 4'h8};
	always #2.5 clock = ~clock;
	uep_ep0_ctrl u_uep_ep0_ctrl (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_in(link_in), .link_out(link_out));
	uep_link_model u_uep_link_model (.clock(clock), .nrst(nrst), .dly(dly), .ev(ev),
		.lo(link_out), .li(link_in));
	// Count one-cycle command pulses
	always @(posedge clock) begin
		n_fl += (link_out.fifo_flush === 1'b1) ? 1 : 0;
		n_hnp += (link_out.hnp_start === 1'b1) ? 1 : 0;
		n_srp += (link_out.srp_start === 1'b1) ? 1 : 0;
		n_disc += (link_out.soft_disc === 1'b1) ? 1 : 0;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// Read, then compare the masked value
	task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
		chk(v & m, e);
	endtask
	task automatic fire(input uep_pkg::uep_link_in_t m);
		@(posedge clock);
		ev <= ev | m;
		@(posedge clock);
		ev <= ev & ~m;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog far beyond the expected run
	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		dly = 4'h0;
		ev = '0;
		ev.rx_bytes = 8'h2a;
		repeat (3) @(posedge clock);
		chk({13'h0000, link_out.speed}, 16'h0002);
		nrst <= 1'b1;
		wr(uep_pkg::OFS_CFG, 16'hffff);
		wr(uep_pkg::OFS_CNT0, 16'hffff);
		wr(4'hf, 16'hffff);
		rdc(uep_pkg::OFS_CFG, 16'hffff, {8'h00, uep_pkg::CFG_FLAGS});
		rdc(uep_pkg::OFS_CNT0, 16'hffff, 16'h002a);
		rdc(4'hf, 16'hffff, 16'h0000);
		wr(uep_pkg::OFS_NAKL, 16'hffff);
		rdc(uep_pkg::OFS_NAKL, 16'hffff, 16'h001f);
		wr(uep_pkg::OFS_TEST, 16'h0040);
		idle(4);
		rdc(uep_pkg::OFS_TEST, 16'h0040, 16'h0000);
		wr(uep_pkg::OFS_TEST, 16'h0010);
		fire('{usb_reset: 1'b1, default: '0});
		idle(2);
		chk({13'h0000, link_out.speed}, 16'h0004);
		for (int i = 0; i < 5; i++) begin
			wr(uep_pkg::OFS_TEST, tm_w[i]);
			idle(3);
			chk({12'h000, link_out.test_packet, link_out.drive_k, link_out.drive_j,
				link_out.nak_all_in}, {12'h000, tm_e[i]});
		end
		// Full speed forced over high speed; K must not drive at full speed
		wr(uep_pkg::OFS_TEST, 16'h0034);
		fire('{usb_reset: 1'b1, default: '0});
		idle(3);
		chk({13'h0000, link_out.speed}, 16'h0002);
		chk({15'h0000, link_out.drive_k}, 16'h0000);
		wr(uep_pkg::OFS_TEST, 16'h0000);
		// Chirp outcome alone selects high speed on a bus reset
		fire('{usb_reset: 1'b1, hs_chirp_ok: 1'b1, default: '0});
		idle(2);
		chk({13'h0000, link_out.speed}, 16'h0004);
		// Transmit ready with a prompt and a slow partner
		for (int d = 0; d < 7; d += 6) begin
			@(posedge clock) dly <= 4'(d);
			wr(uep_pkg::OFS_EP0, 16'h0002);
			idle(1);
			chk({15'h0000, link_out.tx_armed}, 16'h0001);
			for (int k = 0; k < 30 && link_out.tx_armed === 1'b1; k++) @(posedge clock);
			rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0000);
		end
		wr(uep_pkg::OFS_EP0, 16'h0020);
		idle(12);
		rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0004);
		wr(uep_pkg::OFS_EP0, 16'h0000);
		rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0000);
		fire('{rx_got: 1'b1, default: '0});
		rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0001);
		wr(uep_pkg::OFS_EP0, 16'h0100);
		rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0000);
		fire('{rx_got: 1'b1, default: '0});
		wr(uep_pkg::OFS_EP0, 16'h0040);
		rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0000);
		fire('{ctrl_done: 1'b1, default: '0});
		rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0010);
		wr(uep_pkg::OFS_EP0, 16'h0080);
		rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0000);
		wr(uep_pkg::OFS_EP0, 16'h0008);
		fire('{ctrl_done: 1'b1, default: '0});
		rdc(uep_pkg::OFS_EP0, 16'hffff, 16'h0000);
		chk(n_fl[15:0], 16'h0002);
		// Forced host, low speed, as the A device
		wr(uep_pkg::OFS_TEST, 16'h0080);
		wr(uep_pkg::OFS_ROLE, 16'h0001);
		idle(3);
		chk({13'h0000, link_out.speed}, 16'h0001);
		rdc(uep_pkg::OFS_ROLE, 16'h0085, 16'h0005);
		@(posedge clock) ev.peer_connect <= 1'b1;
		ev.peer_low <= 1'b1;
		idle(3);
		rdc(uep_pkg::OFS_ROLE, 16'h0060, 16'h0020);
		@(posedge clock) ev.peer_low <= 1'b0;
		idle(3);
		rdc(uep_pkg::OFS_ROLE, 16'h0060, 16'h0040);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock) ev.above_sess_end <= (i > 0);
			ev.above_a_valid <= (i > 1);
			ev.above_vbus_valid <= (i > 2);
			idle(2);
			rdc(uep_pkg::OFS_ROLE, 16'h0018, 16'(i << 3));
		end
		for (int i = 1; i < 4; i++) begin
			fire('{no_answer: 1'b1, default: '0});
			rdc(uep_pkg::OFS_EP0, 16'h0010, (i == 3) ? 16'h0010 : 16'h0000);
		end
		fire('{stall_got: 1'b1, default: '0});
		rdc(uep_pkg::OFS_EP0, 16'h0014, 16'h0014);
		wr(uep_pkg::OFS_EP0, 16'h0000);
		// An ack answer restarts the count of silent attempts
		repeat (2) fire('{no_answer: 1'b1, default: '0});
		fire('{ack_got: 1'b1, default: '0});
		fire('{no_answer: 1'b1, default: '0});
		rdc(uep_pkg::OFS_EP0, 16'h0010, 16'h0000);
		wr(uep_pkg::OFS_NAKL, 16'h0002);
		fire('{nak_got: 1'b1, default: '0});
		fire('{frame_tick: 1'b1, default: '0});
		rdc(uep_pkg::OFS_EP0, 16'h0080, 16'h0000);
		repeat (3) fire('{frame_tick: 1'b1, default: '0});
		rdc(uep_pkg::OFS_EP0, 16'h0080, 16'h0080);
		chk({15'h0000, link_out.ep0_halted}, 16'h0001);
		wr(uep_pkg::OFS_EP0, 16'h0000);
		idle(2);
		chk({15'h0000, link_out.ep0_halted}, 16'h0000);
		wr(uep_pkg::OFS_EP0, 16'h0820);
		idle(2);
		chk({14'h0000, link_out.no_ping, link_out.in_req}, 16'h0003);
		fire('{rx_got: 1'b1, default: '0});
		rdc(uep_pkg::OFS_EP0, 16'h0021, 16'h0001);
		// Setup token and status toggle ride with transmit ready, dropped once sent
		wr(uep_pkg::OFS_EP0, 16'h004a);
		idle(2);
		chk({13'h0000, link_out.setup_sel, link_out.force_data1, link_out.tx_armed},
			16'h0007);
		idle(10);
		chk({13'h0000, link_out.setup_sel, link_out.force_data1, link_out.tx_armed},
			16'h0000);
		wr(uep_pkg::OFS_TEST, 16'h0000);
		wr(uep_pkg::OFS_ROLE, 16'h0000);
		idle(3);
		chk({15'h0000, link_out.host_mode}, 16'h0000);
		// B device: session request, negotiation, software disconnect
		@(posedge clock) ev.id_b <= 1'b1;
		wr(uep_pkg::OFS_ROLE, 16'h0001);
		idle(2);
		chk(n_srp[15:0], 16'h0001);
		fire('{sess_start: 1'b1, default: '0});
		rdc(uep_pkg::OFS_ROLE, 16'h0081, 16'h0081);
		wr(uep_pkg::OFS_ROLE, 16'h0003);
		fire('{suspend_enter: 1'b1, default: '0});
		idle(2);
		chk(n_hnp[15:0], 16'h0001);
		fire('{hnp_done: 1'b1, default: '0});
		rdc(uep_pkg::OFS_ROLE, 16'h0002, 16'h0000);
		@(posedge clock) ev.suspended <= 1'b1;
		wr(uep_pkg::OFS_ROLE, 16'h0000);
		idle(2);
		chk(n_disc[15:0], 16'h0001);
		rdc(uep_pkg::OFS_ROLE, 16'h0001, 16'h0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
